/* logic/dpac_checker.sv */
`timescale 1ns/1ps
module dpac_checker #(
	parameter logic [15:0] MODEL_ID = 16'h00a5, // arbitrary value
	parameter logic [15:0] POWER_CODE = 16'h0004,
	parameter logic [15:0] SUPPLY_CLASS = 16'h0001,
	parameter logic [15:0] FW_VERSION = 16'h0100,
	parameter logic [15:0] SPEED_MAX = 16'h2ee0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic [7:0] req_func,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_data,
	input wire logic motor_running,
	output logic req_ready,
	output logic rsp_valid,
	output logic rsp_ack,
	output logic [7:0] rsp_start_byte,
	output logic [7:0] rsp_end_byte,
	output logic [7:0] rsp_func,
	output logic [7:0] bad_code_hi,
	output logic [7:0] bad_code_lo,
	output logic [15:0] rsp_data,
	output logic [15:0] speed_setpoint_out,
	output logic run_stop,
	output logic run_forward,
	output logic run_reverse,
	output logic emergency_stop,
	output logic [1:0] cmd_source,
	output logic fault_clear
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic is_valid_func(input logic [7:0] f);
		// lower-case letters fall out here, no case folding on purpose
		is_valid_func = (f == dpac_pkg::FUNC_READ) || (f == dpac_pkg::FUNC_WRITE) ||
			(f == dpac_pkg::FUNC_MON_REG) || (f == dpac_pkg::FUNC_MON_ACT);
	endfunction

	function automatic logic [15:0] err_ascii(input dpac_pkg::dpac_err_e e);
		case (e)
			dpac_pkg::ERR_FUNC: begin
				err_ascii = dpac_pkg::CODE_FUNC;
			end
			dpac_pkg::ERR_ADDR: begin
				err_ascii = dpac_pkg::CODE_ADDR;
			end
			dpac_pkg::ERR_LOCK: begin
				err_ascii = dpac_pkg::CODE_LOCK;
			end
			dpac_pkg::ERR_VALUE: begin
				err_ascii = dpac_pkg::CODE_VALUE;
			end
			default: begin
				err_ascii = 16'h2020; // blanks, never sent in a NAK
			end
		endcase
	endfunction

	logic [15:0] speed_setpoint;
	logic [15:0] drive_command_word;
	logic addr_exists;
	logic addr_writable;
	logic value_ok;
	dpac_pkg::dpac_err_e next_err;
	logic [15:0] next_read;
	logic write_ok;
	logic [15:0] next_code;

	// ****************************************
	// parameter table
	// ****************************************
	dpac_param_rules u_rules (
		.addr(req_addr),
		.data(req_data),
		.command_now(drive_command_word),
		.speed_max(SPEED_MAX),
		.motor_running(motor_running),
		.exists(addr_exists),
		.writable(addr_writable),
		.value_ok(value_ok)
	);

	// every request is taken the cycle it arrives
	assign req_ready = 1'b1;

	// ****************************************
	// request checking
	// ****************************************
	// first failure wins; monitor commands carry no single address here
	always_comb begin
		next_err = dpac_pkg::ERR_NONE;
		if (!is_valid_func(req_func)) begin
			next_err = dpac_pkg::ERR_FUNC;
		end else if ((req_func == dpac_pkg::FUNC_READ || req_func == dpac_pkg::FUNC_WRITE) && !addr_exists) begin
			next_err = dpac_pkg::ERR_ADDR;
		end else if (req_func == dpac_pkg::FUNC_WRITE && !addr_writable) begin
			next_err = dpac_pkg::ERR_LOCK;
		end else if (req_func == dpac_pkg::FUNC_WRITE && !value_ok) begin
			next_err = dpac_pkg::ERR_VALUE;
		end
	end

	assign write_ok = req_valid && (req_func == dpac_pkg::FUNC_WRITE) && (next_err == dpac_pkg::ERR_NONE);
	assign next_code = err_ascii(next_err);

	// read mux of the common area, same addresses for every model
	always_comb begin
		case (req_addr)
			dpac_pkg::ADDR_MODEL: begin
				next_read = MODEL_ID;
			end
			dpac_pkg::ADDR_POWER: begin
				next_read = POWER_CODE;
			end
			dpac_pkg::ADDR_SUPPLY: begin
				next_read = SUPPLY_CLASS;
			end
			dpac_pkg::ADDR_FIRMWARE: begin
				next_read = FW_VERSION;
			end
			dpac_pkg::ADDR_SPEED: begin
				next_read = speed_setpoint;
			end
			dpac_pkg::ADDR_COMMAND: begin
				next_read = drive_command_word;
			end
			default: begin
				next_read = dpac_pkg::DATA_RESET;
			end
		endcase
	end

	// ****************************************
	// writable parameters
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			speed_setpoint <= dpac_pkg::SPEED_RESET;
		end else if (write_ok && req_addr == dpac_pkg::ADDR_SPEED) begin
			speed_setpoint <= req_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			drive_command_word <= dpac_pkg::COMMAND_RESET;
		end else if (write_ok && req_addr == dpac_pkg::ADDR_COMMAND) begin
			drive_command_word <= req_data;
		end
	end

	// fault clear is an edge: rewriting a steady 1 must not clear again
	always_ff @(posedge clk) begin
		if (rst) begin
			fault_clear <= 1'b0;
		end else begin
			fault_clear <= write_ok && (req_addr == dpac_pkg::ADDR_COMMAND) &&
				req_data[dpac_pkg::CMD_FAULT_RESET_BIT] &&
				!drive_command_word[dpac_pkg::CMD_FAULT_RESET_BIT];
		end
	end

	// bit 5 is left unused by the drive
	assign run_stop = drive_command_word[dpac_pkg::CMD_STOP_BIT];
	assign run_forward = drive_command_word[dpac_pkg::CMD_FWD_BIT];
	assign run_reverse = drive_command_word[dpac_pkg::CMD_REV_BIT];
	assign emergency_stop = drive_command_word[dpac_pkg::CMD_ESTOP_BIT];
	assign cmd_source = drive_command_word[dpac_pkg::CMD_SRC_LSB +: 2];
	assign speed_setpoint_out = speed_setpoint;

	// ****************************************
	// response
	// ****************************************
	// write ack returns the word held before the write
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_ack <= 1'b0;
			rsp_start_byte <= dpac_pkg::FRAME_ACK;
			rsp_end_byte <= dpac_pkg::FRAME_END;
			rsp_func <= 8'h00;
			bad_code_hi <= 8'h20;
			bad_code_lo <= 8'h20;
			rsp_data <= dpac_pkg::DATA_RESET;
		end else begin
			rsp_valid <= req_valid;
			if (req_valid) begin
				rsp_ack <= (next_err == dpac_pkg::ERR_NONE);
				rsp_start_byte <= (next_err == dpac_pkg::ERR_NONE) ? dpac_pkg::FRAME_ACK : dpac_pkg::FRAME_NAK;
				rsp_end_byte <= dpac_pkg::FRAME_END;
				rsp_func <= req_func;
				bad_code_hi <= next_code[15:8];
				bad_code_lo <= next_code[7:0];
				rsp_data <= (next_err == dpac_pkg::ERR_NONE &&
					(req_func == dpac_pkg::FUNC_READ || req_func == dpac_pkg::FUNC_WRITE)) ?
					next_read : dpac_pkg::DATA_RESET;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	bad_func_a: assert property (@(posedge clk) disable iff (rst)
		req_valid && !is_valid_func(req_func) |=> rsp_valid && !rsp_ack &&
		{bad_code_hi, bad_code_lo} == dpac_pkg::CODE_FUNC)
		else $error("bad function not refused");

	bad_addr_a: assert property (@(posedge clk) disable iff (rst)
		req_valid && req_func == dpac_pkg::FUNC_READ && req_addr == 16'h0004 |=>
		!rsp_ack && {bad_code_hi, bad_code_lo} == dpac_pkg::CODE_ADDR)
		else $error("missing address not refused");

	bad_value_a: assert property (@(posedge clk) disable iff (rst)
		req_valid && req_func == dpac_pkg::FUNC_WRITE && req_addr == dpac_pkg::ADDR_SPEED &&
		req_data > SPEED_MAX |=> !rsp_ack && {bad_code_hi, bad_code_lo} == dpac_pkg::CODE_VALUE &&
		speed_setpoint == $past(speed_setpoint))
		else $error("out of range speed accepted");

	ro_write_a: assert property (@(posedge clk) disable iff (rst)
		req_valid && req_func == dpac_pkg::FUNC_WRITE && req_addr == dpac_pkg::ADDR_FIRMWARE |=>
		!rsp_ack && {bad_code_hi, bad_code_lo} == dpac_pkg::CODE_LOCK)
		else $error("read only write accepted");

	power_read_a: assert property (@(posedge clk) disable iff (rst)
		req_valid && req_func == dpac_pkg::FUNC_READ && req_addr == dpac_pkg::ADDR_POWER |=>
		rsp_ack && rsp_data == POWER_CODE)
		else $error("power code read wrong");

	fault_edge_a: assert property (@(posedge clk) disable iff (rst)
		fault_clear |-> drive_command_word[dpac_pkg::CMD_FAULT_RESET_BIT] &&
		!$past(drive_command_word[dpac_pkg::CMD_FAULT_RESET_BIT]))
		else $error("fault clear without rising edge");

	estop_write_a: assert property (@(posedge clk) disable iff (rst)
		write_ok && req_addr == dpac_pkg::ADDR_COMMAND && req_data[dpac_pkg::CMD_ESTOP_BIT] |=>
		emergency_stop ##1 (emergency_stop || $past(write_ok)))
		else $error("emergency stop not raised");

	source_write_a: assert property (@(posedge clk) disable iff (rst)
		write_ok && req_addr == dpac_pkg::ADDR_COMMAND |=>
		cmd_source == $past(req_data[7:6]) && run_forward == $past(req_data[1]))
		else $error("command fields not taken");

	nak_frame_a: assert property (@(posedge clk) disable iff (rst)
		rsp_valid && !rsp_ack |-> rsp_start_byte == dpac_pkg::FRAME_NAK &&
		rsp_end_byte == dpac_pkg::FRAME_END)
		else $error("nak frame bytes wrong");

	code_print_a: assert property (@(posedge clk) disable iff (rst)
		rsp_valid && !rsp_ack |-> bad_code_hi >= dpac_pkg::PRINT_MIN && bad_code_hi <= dpac_pkg::PRINT_MAX &&
		bad_code_lo >= dpac_pkg::PRINT_MIN && bad_code_lo <= dpac_pkg::PRINT_MAX)
		else $error("error code not printable");

	check_order_a: assert property (@(posedge clk) disable iff (rst)
		req_valid && req_func == dpac_pkg::FUNC_WRITE && !addr_exists |=>
		{bad_code_hi, bad_code_lo} == dpac_pkg::CODE_ADDR)
		else $error("address check not ahead of permission");

	rsp_pulse_a: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> rsp_valid == $past(req_valid))
		else $error("answer pulse not one cycle after request");

	fault_pulse_a: assert property (@(posedge clk) disable iff (rst)
		fault_clear |=> !fault_clear)
		else $error("fault clear held on a steady level");

	// a refused source change must leave the running source in place
	run_lock_a: assert property (@(posedge clk) disable iff (rst)
		req_valid && req_func == dpac_pkg::FUNC_WRITE && req_addr == dpac_pkg::ADDR_COMMAND &&
		motor_running && req_data[dpac_pkg::CMD_SRC_LSB +: 2] != cmd_source |=>
		!rsp_ack && {bad_code_hi, bad_code_lo} == dpac_pkg::CODE_LOCK &&
		cmd_source == $past(cmd_source))
		else $error("source change accepted while running");

	monitor_ack_a: assert property (@(posedge clk) disable iff (rst)
		req_valid && (req_func == dpac_pkg::FUNC_MON_REG || req_func == dpac_pkg::FUNC_MON_ACT) |=>
		rsp_ack && rsp_data == dpac_pkg::DATA_RESET)
		else $error("monitor request not acknowledged");

	read_cover_c: cover property (@(posedge clk) req_valid && req_func == dpac_pkg::FUNC_READ ##1 rsp_ack);
	write_cover_c: cover property (@(posedge clk) write_ok && req_addr == dpac_pkg::ADDR_SPEED);
	fault_cover_c: cover property (@(posedge clk) fault_clear);
	lock_cover_c: cover property (@(posedge clk) req_valid && next_err == dpac_pkg::ERR_LOCK && motor_running);

endmodule

/* logic/dpac_param_rules.sv */
`timescale 1ns/1ps
// per-parameter existence, write permission and range table
module dpac_param_rules (
	input wire logic [15:0] addr,
	input wire logic [15:0] data,
	input wire logic [15:0] command_now,
	input wire logic [15:0] speed_max,
	input wire logic motor_running,
	output logic exists,
	output logic writable,
	output logic value_ok
);

	// ****************************************
	// address table
	// ****************************************
	// the common area is fixed, so no model input steers it
	always_comb begin
		case (addr)
			dpac_pkg::ADDR_MODEL, dpac_pkg::ADDR_POWER, dpac_pkg::ADDR_SUPPLY,
			dpac_pkg::ADDR_FIRMWARE, dpac_pkg::ADDR_SPEED, dpac_pkg::ADDR_COMMAND: begin
				exists = 1'b1;
			end
			default: begin
				exists = 1'b0;
			end
		endcase
	end

	// ****************************************
	// write permission
	// ****************************************
	// changing the command source while the motor turns would hand control away mid-run
	always_comb begin
		case (addr)
			dpac_pkg::ADDR_SPEED: begin
				writable = 1'b1;
			end
			dpac_pkg::ADDR_COMMAND: begin
				writable = !(motor_running &&
					(data[dpac_pkg::CMD_SRC_LSB +: 2] != command_now[dpac_pkg::CMD_SRC_LSB +: 2]));
			end
			default: begin
				writable = 1'b0;
			end
		endcase
	end

	// ****************************************
	// value range
	// ****************************************
	always_comb begin
		case (addr)
			dpac_pkg::ADDR_SPEED: begin
				value_ok = (data <= speed_max);
			end
			dpac_pkg::ADDR_COMMAND: begin
				value_ok = ((data & ~dpac_pkg::CMD_USED_MASK) == 16'h0000);
			end
			default: begin
				value_ok = 1'b1;
			end
		endcase
	end

endmodule

/* logic/dpac_pkg.sv */
package dpac_pkg;

	// ****************************************
	// parameter addresses of the common area
	// ****************************************
	localparam logic [15:0] ADDR_MODEL = 16'h0000;
	localparam logic [15:0] ADDR_POWER = 16'h0001;
	localparam logic [15:0] ADDR_SUPPLY = 16'h0002;
	localparam logic [15:0] ADDR_FIRMWARE = 16'h0003;
	localparam logic [15:0] ADDR_SPEED = 16'h0005;
	localparam logic [15:0] ADDR_COMMAND = 16'h0006;

	// ****************************************
	// function letters, upper case only
	// ****************************************
	localparam logic [7:0] FUNC_READ = 8'h52;
	localparam logic [7:0] FUNC_WRITE = 8'h57;
	localparam logic [7:0] FUNC_MON_REG = 8'h58;
	localparam logic [7:0] FUNC_MON_ACT = 8'h59;

	// ****************************************
	// frame bytes and two-letter error codes
	// ****************************************
	localparam logic [7:0] FRAME_ACK = 8'h06;
	localparam logic [7:0] FRAME_NAK = 8'h15;
	localparam logic [7:0] FRAME_END = 8'h04;
	localparam logic [15:0] CODE_FUNC = 16'h4946;
	localparam logic [15:0] CODE_ADDR = 16'h4941;
	localparam logic [15:0] CODE_VALUE = 16'h4944;
	localparam logic [15:0] CODE_LOCK = 16'h574d;
	localparam logic [7:0] PRINT_MIN = 8'h20;
	localparam logic [7:0] PRINT_MAX = 8'h7f;

	// ****************************************
	// run command word fields
	// ****************************************
	localparam int CMD_STOP_BIT = 0;
	localparam int CMD_FWD_BIT = 1;
	localparam int CMD_REV_BIT = 2;
	localparam int CMD_FAULT_RESET_BIT = 3;
	localparam int CMD_ESTOP_BIT = 4;
	localparam int CMD_SRC_LSB = 6;
	localparam logic [15:0] CMD_USED_MASK = 16'h00ff;

	// ****************************************
	// values after reset
	// ****************************************
	localparam logic [15:0] SPEED_RESET = 16'h0000;
	localparam logic [15:0] COMMAND_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	typedef enum logic [1:0] {SRC_TERMINAL, SRC_KEYPAD, SRC_OPTION, SRC_SERIAL} dpac_src_e;
	typedef enum logic [2:0] {ERR_NONE, ERR_FUNC, ERR_ADDR, ERR_LOCK, ERR_VALUE} dpac_err_e;

endpackage

/* tb/dpac_master.sv */
`timescale 1ns/1ps
// ****************************************
// pc-side request driver
// ****************************************
module dpac_master (
	output logic req_valid,
	output logic [7:0] req_func,
	output logic [15:0] req_addr,
	output logic [15:0] req_data
);
	// lines start quiet before reset releases
	initial begin
		req_valid = 1'b0;
		req_func = 8'h00;
		req_addr = 16'h0000;
		req_data = 16'h0000;
	end

	// present one request; the caller holds it across exactly one edge
	task automatic put(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
		req_valid = 1'b1;
		req_func = f;
		req_addr = a;
		req_data = d;
	endtask

	// released lines flip so a stale value can never look like a real field
	task automatic put_idle();
		req_valid = 1'b0;
		req_func = ~req_func;
		req_addr = ~req_addr;
		req_data = ~req_data;
	endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	// ****************************************
	// setup
	// ****************************************
	localparam logic [15:0] MODEL_ID = 16'h0033; // arbitrary value
	localparam logic [15:0] POWER_CODE = 16'h0011;
	localparam logic [15:0] SUPPLY_CLASS = 16'h0000;
	localparam logic [15:0] FW_VERSION = 16'h0101;
	localparam logic [15:0] SPEED_MAX = 16'h1770;
	localparam logic [15:0] OK = 16'h2020;
	typedef struct packed {logic [7:0] f; logic [15:0] a; logic [15:0] d; logic ack; logic [15:0] c; logic [15:0] q;} dpac_row_s;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic motor_running = 1'b0;
	logic req_valid, req_ready, rsp_valid, rsp_ack, run_stop, run_forward, run_reverse, emergency_stop, fault_clear;
	logic [7:0] req_func, rsp_start_byte, rsp_end_byte, rsp_func, bad_code_hi, bad_code_lo;
	logic [15:0] req_addr, req_data, rsp_data, speed_setpoint_out;
	logic [1:0] cmd_source;
	int n_errors = 0;
	int total_checks = 0;
	dpac_row_s rows [0:17];
	logic [15:0] w;

	always #10 clk = ~clk;

	dpac_master u_dpac_master (.req_valid(req_valid), .req_func(req_func), .req_addr(req_addr), .req_data(req_data));

	dpac_checker #(.MODEL_ID(MODEL_ID), .POWER_CODE(POWER_CODE), .SUPPLY_CLASS(SUPPLY_CLASS),
		.FW_VERSION(FW_VERSION), .SPEED_MAX(SPEED_MAX)) u_dpac_checker (
		.clk(clk), .rst(rst), .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
		.req_data(req_data), .motor_running(motor_running), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_ack(rsp_ack), .rsp_start_byte(rsp_start_byte), .rsp_end_byte(rsp_end_byte), .rsp_func(rsp_func),
		.bad_code_hi(bad_code_hi), .bad_code_lo(bad_code_lo), .rsp_data(rsp_data),
		.speed_setpoint_out(speed_setpoint_out), .run_stop(run_stop), .run_forward(run_forward),
		.run_reverse(run_reverse), .emergency_stop(emergency_stop), .cmd_source(cmd_source),
		.fault_clear(fault_clear));

	// ****************************************
	// check and drive tasks
	// ****************************************
	task automatic chk1(input string name, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// requests are launched 1 ns after an edge and answered at the next edge;
	// one idle edge first, so a release and a new request never share a time step
	task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		u_dpac_master.put(f, a, d);
		@(posedge clk);
		#1;
		u_dpac_master.put_idle();
	endtask

	task automatic rsp_chk(input logic [7:0] f, input logic ack, input logic [15:0] c, input logic [15:0] q);
		chk1("rsp_valid", 1'b1, rsp_valid);
		chk1("rsp_ack", ack, rsp_ack);
		chk16("start", {8'h00, ack ? dpac_pkg::FRAME_ACK : dpac_pkg::FRAME_NAK}, {8'h00, rsp_start_byte});
		chk16("end", {8'h00, dpac_pkg::FRAME_END}, {8'h00, rsp_end_byte});
		chk16("func", {8'h00, f}, {8'h00, rsp_func});
		chk16("code", c, {bad_code_hi, bad_code_lo});
		chk16("data", q, rsp_data);
		chk1("printable", 1'b1, bad_code_hi >= 8'h20 && bad_code_hi <= 8'h7f && bad_code_lo >= 8'h20 && bad_code_lo <= 8'h7f);
	endtask

	task automatic reset_chk();
		chk1("rsp_valid", 1'b0, rsp_valid);
		chk1("ready", 1'b1, req_ready);
		chk16("start", 16'h0006, {8'h00, rsp_start_byte});
		chk16("code", OK, {bad_code_hi, bad_code_lo});
		chk16("speed", 16'h0000, speed_setpoint_out);
		chk16("cmd", 16'h0000, {9'h000, emergency_stop, fault_clear, run_reverse, run_forward, run_stop, cmd_source});
	endtask

	task automatic do_reset();
		rst = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		reset_chk();
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// watchdog: the tests need well under 300 cycles
	// ****************************************
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		final_report();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rows = '{
			'{8'h52, 16'h0000, 16'h0000, 1'b1, OK, MODEL_ID},
			'{8'h52, 16'h0001, 16'h0000, 1'b1, OK, POWER_CODE},
			'{8'h52, 16'h0002, 16'h0000, 1'b1, OK, SUPPLY_CLASS},
			'{8'h52, 16'h0003, 16'h0000, 1'b1, OK, FW_VERSION},
			'{8'h52, 16'h0004, 16'h0000, 1'b0, dpac_pkg::CODE_ADDR, 16'h0000},
			'{8'h52, 16'h0007, 16'h0000, 1'b0, dpac_pkg::CODE_ADDR, 16'h0000},
			'{8'h72, 16'h0001, 16'h0000, 1'b0, dpac_pkg::CODE_FUNC, 16'h0000},
			'{8'h41, 16'h0001, 16'h0000, 1'b0, dpac_pkg::CODE_FUNC, 16'h0000},
			'{8'h77, 16'h0004, 16'hffff, 1'b0, dpac_pkg::CODE_FUNC, 16'h0000},
			'{8'h57, 16'h0009, 16'hffff, 1'b0, dpac_pkg::CODE_ADDR, 16'h0000},
			'{8'h57, 16'h0003, 16'h0200, 1'b0, dpac_pkg::CODE_LOCK, 16'h0000},
			'{8'h57, 16'h0000, 16'hffff, 1'b0, dpac_pkg::CODE_LOCK, 16'h0000},
			'{8'h57, 16'h0005, SPEED_MAX + 16'h0001, 1'b0, dpac_pkg::CODE_VALUE, 16'h0000},
			'{8'h57, 16'h0005, SPEED_MAX, 1'b1, OK, 16'h0000},
			'{8'h52, 16'h0005, 16'h0000, 1'b1, OK, SPEED_MAX},
			'{8'h57, 16'h0006, 16'h0100, 1'b0, dpac_pkg::CODE_VALUE, 16'h0000},
			'{8'h58, 16'h0001, 16'h0000, 1'b1, OK, 16'h0000},
			'{8'h59, 16'h0001, 16'h0000, 1'b1, OK, 16'h0000}};
		do_reset();
		// table of ordinary requests and refusals
		foreach (rows[i]) begin
			req(rows[i].f, rows[i].a, rows[i].d);
			rsp_chk(rows[i].f, rows[i].ack, rows[i].c, rows[i].q);
		end
		chk16("speed", SPEED_MAX, speed_setpoint_out);
		// back to back: second request rides on the edge that answers the first
		@(posedge clk);
		#1;
		u_dpac_master.put(8'h52, 16'h0003, 16'h0000);
		@(posedge clk);
		#1;
		u_dpac_master.put(8'h52, 16'h0001, 16'h0000);
		rsp_chk(8'h52, 1'b1, OK, FW_VERSION);
		@(posedge clk);
		#1;
		u_dpac_master.put_idle();
		rsp_chk(8'h52, 1'b1, OK, POWER_CODE);
		// every command source
		for (int s = 0; s < 4; s++) begin
			req(8'h57, 16'h0006, {8'h00, s[1:0], 6'h00});
			chk16("source", {14'h0000, s[1:0]}, {14'h0000, cmd_source});
		end
		// command bits 0 to 4 each alone; bit 3 raised from 0 gives one clear pulse
		for (int b = 0; b < 5; b++) begin
			w = 16'h0001 << b;
			req(8'h57, 16'h0006, w);
			chk16("bits", {11'h000, w[4], b == 3, w[2:0]},
				{11'h000, emergency_stop, fault_clear, run_reverse, run_forward, run_stop});
		end
		req(8'h57, 16'h0006, 16'h0008);
		chk1("fault_clear", 1'b1, fault_clear);
		@(posedge clk);
		#1;
		chk1("fault_clear", 1'b0, fault_clear);
		chk1("rsp_valid", 1'b0, rsp_valid);
		req(8'h57, 16'h0006, 16'h0008);
		chk1("fault_clear", 1'b0, fault_clear);
		// source change is locked while the motor runs
		motor_running = 1'b1;
		req(8'h57, 16'h0006, 16'h00c0);
		rsp_chk(8'h57, 1'b0, dpac_pkg::CODE_LOCK, 16'h0000);
		chk16("source", 16'h0000, {14'h0000, cmd_source});
		req(8'h57, 16'h0006, 16'h0002);
		rsp_chk(8'h57, 1'b1, OK, 16'h0008);
		chk1("run_forward", 1'b1, run_forward);
		motor_running = 1'b0;
		// second reset in mid-run
		do_reset();
		final_report();
	end
endmodule
